// >>> include/rsr_pkg.sv
// Constants and carrier types for the redundancy switch request block
package rsr_pkg;

    localparam int unsigned CONN_COUNT        = 22;
    localparam int unsigned USER_CONN_FIRST   = 1;
    localparam int unsigned USER_CONN_LAST    = 16;
    localparam int unsigned USER_CONN_COUNT   = USER_CONN_LAST - USER_CONN_FIRST + 1;

    localparam logic [7:0]  ADDR_HUB_LINK_STATE = 8'hC9;
    localparam logic [7:0]  ADDR_CONTROL        = 8'hD0;
    localparam logic [7:0]  ADDR_MONITOR_LO     = 8'hD1;
    localparam logic [7:0]  ADDR_MONITOR_HI     = 8'hD2;
    localparam logic [7:0]  ADDR_DISC_TIME      = 8'hD3;
    localparam logic [7:0]  ADDR_IRQ_STATUS     = 8'hD4;
    localparam logic [7:0]  ADDR_IRQ_MASK       = 8'hD5;
    localparam logic [7:0]  ADDR_ERR_LO         = 8'hD6;
    localparam logic [7:0]  ADDR_ERR_HI         = 8'hD7;

    localparam int unsigned CTRL_REQ_ENABLE_BIT = 0;
    localparam int unsigned CTRL_ACTIVE_BIT     = 1;
    localparam int unsigned CTRL_INIT_DONE_BIT  = 2;

    localparam int unsigned IRQ_COMM_BIT        = 0;
    localparam int unsigned IRQ_DISC_BIT        = 1;
    localparam int unsigned IRQ_LINK_LOST_BIT   = 2;
    localparam int unsigned IRQ_WIDTH           = 3;

    localparam logic [15:0] LINK_GOOD_WORD      = 16'h0001;
    localparam logic [15:0] LINK_LOST_WORD      = 16'h0000;
    localparam logic [15:0] CONTROL_RESET       = 16'h0000;
    localparam logic [15:0] DISC_TIME_RESET     = 16'h0001;

    localparam int unsigned CLK_PERIOD_NS       = 10;
    localparam int unsigned MS_TICK_NS          = 1000000;
    localparam int unsigned MS_TICK_CYCLES      = MS_TICK_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } rsr_bus_req_type;

    typedef struct packed {
        logic [CONN_COUNT-1:0] open;
        logic [CONN_COUNT-1:0] alive_fail;
        logic [CONN_COUNT-1:0] ack_fail;
    } rsr_conn_event_type;

endpackage

// >>> design/rsr_disc_timer.sv
// Link loss debounce timer for the redundancy switch request block
`timescale 1ns/10ps
`default_nettype none
module rsr_disc_timer (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_armed,
    input  wire logic        i_link_up,
    input  wire logic [15:0] i_limit_ms,
    output logic             o_link_good,
    output logic             o_lost_edge,
    output logic             o_expired
);
    typedef enum logic [1:0] {
        RSR_IDLE,
        RSR_GOOD,
        RSR_TIMING,
        RSR_LOST
    } rsr_state_type;

    rsr_state_type state_q;
    logic [31:0]   tick_cnt_q;
    logic          tick_q;
    logic [15:0]   ms_cnt_q;

    // Millisecond enable, runs only while a loss is being timed
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tick_cnt_q <= 32'h0;
            tick_q     <= 1'b0;
        end else if (state_q != RSR_TIMING) begin
            // Restart at each loss, else the first millisecond comes short [RL13]
            tick_cnt_q <= 32'h0;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == 32'(rsr_pkg::MS_TICK_CYCLES - 1)) begin
            tick_cnt_q <= 32'h0;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            tick_q     <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q     <= RSR_IDLE;
            ms_cnt_q    <= 16'h0;
            o_lost_edge <= 1'b0;
            o_expired   <= 1'b0;
        end else begin
            o_lost_edge <= 1'b0;
            o_expired   <= 1'b0;
            case (state_q)
                RSR_IDLE: begin
                    // Link never seen up is not a disconnection [RL12] [RL15]
                    if (i_armed && i_link_up) begin
                        state_q <= RSR_GOOD;
                    end
                end
                RSR_GOOD: begin
                    if (!i_link_up) begin
                        state_q     <= RSR_TIMING;
                        ms_cnt_q    <= 16'h0;
                        o_lost_edge <= 1'b1;
                    end
                end
                RSR_TIMING: begin
                    if (i_link_up) begin
                        state_q <= RSR_GOOD; // [RL14]
                    end else if (ms_cnt_q >= i_limit_ms) begin
                        state_q   <= RSR_LOST;
                        o_expired <= 1'b1; // [RL13]
                    end else if (tick_q) begin
                        ms_cnt_q <= ms_cnt_q + 16'h1;
                    end
                end
                RSR_LOST: begin
                    // One request per outage [RL17]
                    if (i_link_up) begin
                        state_q <= RSR_GOOD;
                    end
                end
                default: state_q <= RSR_IDLE;
            endcase
            if (!i_armed) begin
                state_q <= RSR_IDLE;
            end
        end
    end

    assign o_link_good = (state_q == RSR_GOOD);
endmodule
`default_nettype wire

// >>> design/rsr_switch_request.sv
// Switch request logic: connection faults and link loss to host CPU
//
// Operation
// (RL1) Failed presence check on a monitored open connection raises a request.
// (RL2) Missing TCP acknowledgement before the ack timer expires raises a request.
// (RL3) Link state is watched continuously; loss is a possible switch cause.
// (RL4) Host skips switchover when the standby unit is already faulty.
// (RL5) Host ignores request while the other group member works normally.
// (RL6) Each connection monitored separately; only selected ones are checked.
// (RL7) Selectable set: user connections 1 to 16 plus fixed system ports.
// (RL8) Presence check failure closes the connection, then raises the request.
// (RL9) Ack timeout on open or send flags send error, then raises request.
// (RL10) Communication faults raise requests only when issuing is enabled.
// (RL11) Current link result is kept in a host readable status word.
// (RL12) Only a good-to-lost transition counts as a disconnection.
// (RL13) Request only if link loss lasts the whole monitoring time.
// (RL14) Link back before the monitoring time cancels timing, no request.
// (RL15) Disconnection detection starts only after initialisation completes.
// (RL16) Only the unit on the active CPU raises switch requests.
// (RL17) Request is a one-cycle pulse, not repeated until the fault clears.
// (RL18) Link word reads 1 while good, 0 after disconnection, holds otherwise.
`timescale 1ns/10ps
`default_nettype none
module rsr_switch_request (
    input  wire logic                       i_clk,
    input  wire logic                       i_reset_n,
    input  wire rsr_pkg::rsr_bus_req_type   i_bus,
    output logic [15:0]                     o_rdata,
    input  wire rsr_pkg::rsr_conn_event_type i_conn,
    input  wire logic                       i_link_up,
    output logic                            o_switch_req,
    output logic [rsr_pkg::CONN_COUNT-1:0]  o_conn_close,
    output logic                            o_send_error,
    output logic                            o_irq
);
    localparam int unsigned N = rsr_pkg::CONN_COUNT;

    logic [1:0]   link_sync_q;
    logic         link_up;
    logic [15:0]  control_q;
    logic [N-1:0] monitor_q;
    logic [15:0]  disc_time_q;
    logic [15:0]  link_word_q;
    logic [rsr_pkg::IRQ_WIDTH-1:0] irq_status_q;
    logic [rsr_pkg::IRQ_WIDTH-1:0] irq_mask_q;
    logic [N-1:0] err_latch_q;
    logic [N-1:0] new_fault;
    logic         req_enable;
    logic         active_cpu;
    logic         init_done;
    logic         comm_req;
    logic         disc_req;
    logic         link_good;
    logic         lost_edge;
    logic         wr_status;
    logic [rsr_pkg::IRQ_WIDTH-1:0] irq_events;

    assign req_enable = control_q[rsr_pkg::CTRL_REQ_ENABLE_BIT];
    assign active_cpu = control_q[rsr_pkg::CTRL_ACTIVE_BIT];
    assign init_done  = control_q[rsr_pkg::CTRL_INIT_DONE_BIT];

    // Link pin comes from the PHY domain
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            link_sync_q <= 2'b00;
        end else begin
            link_sync_q <= {link_sync_q[0], i_link_up}; // [RL3]
        end
    end
    assign link_up = link_sync_q[1];

    // Software registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            control_q   <= rsr_pkg::CONTROL_RESET;
            monitor_q   <= '0;
            disc_time_q <= rsr_pkg::DISC_TIME_RESET;
            irq_mask_q  <= '0;
        end else if (i_bus.wr) begin
            case (i_bus.addr)
                rsr_pkg::ADDR_CONTROL:    control_q <= i_bus.wdata;
                rsr_pkg::ADDR_MONITOR_LO: monitor_q[15:0] <= i_bus.wdata; // [RL7]
                rsr_pkg::ADDR_MONITOR_HI: monitor_q[N-1:16] <= i_bus.wdata[N-17:0];
                rsr_pkg::ADDR_DISC_TIME:  disc_time_q <= i_bus.wdata;
                rsr_pkg::ADDR_IRQ_MASK:   irq_mask_q <= i_bus.wdata[rsr_pkg::IRQ_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    // Per-connection fault latches, one request per fault
    generate
        for (genvar g = 0; g < N; g++) begin : g_conn
            logic fault;
            assign fault = i_conn.open[g] && monitor_q[g]
                           && (i_conn.alive_fail[g] || i_conn.ack_fail[g]); // [RL6] [RL1] [RL2]
            assign new_fault[g] = fault && !err_latch_q[g];
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    err_latch_q[g] <= 1'b0;
                end else if (fault) begin
                    err_latch_q[g] <= 1'b1; // [RL17]
                end else if (!i_conn.open[g]) begin
                    err_latch_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Close the connection that failed its presence check; flag send error on an ack failure
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_conn_close <= '0;
            o_send_error <= 1'b0;
        end else begin
            o_conn_close <= new_fault & i_conn.alive_fail; // [RL8]
            o_send_error <= |(new_fault & i_conn.ack_fail); // [RL9]
        end
    end

    // Delayed a cycle so the close is seen before the request
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            comm_req <= 1'b0;
        end else begin
            comm_req <= (|new_fault) && req_enable; // [RL10]
        end
    end

    rsr_disc_timer u_disc_timer (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_armed     (init_done),
        .i_link_up   (link_up),
        .i_limit_ms  (disc_time_q),
        .o_link_good (link_good),
        .o_lost_edge (lost_edge),
        .o_expired   (disc_req)
    );

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_switch_req <= 1'b0;
        end else begin
            o_switch_req <= active_cpu && (comm_req || disc_req); // [RL16] [RL17]
        end
    end

    // Link word: only changes on transitions
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            link_word_q <= rsr_pkg::LINK_LOST_WORD;
        end else if (link_good) begin
            link_word_q <= rsr_pkg::LINK_GOOD_WORD; // [RL11] [RL18]
        end else if (lost_edge) begin
            link_word_q <= rsr_pkg::LINK_LOST_WORD; // [RL18]
        end
    end

    // Sticky status: set beats write-one-to-clear
    assign wr_status = i_bus.wr && (i_bus.addr == rsr_pkg::ADDR_IRQ_STATUS);
    always_comb begin
        irq_events = '0;
        irq_events[rsr_pkg::IRQ_COMM_BIT]      = comm_req;
        irq_events[rsr_pkg::IRQ_DISC_BIT]      = disc_req;
        irq_events[rsr_pkg::IRQ_LINK_LOST_BIT] = lost_edge;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_status_q <= '0;
        end else begin
            irq_status_q <= (irq_status_q
                & ~(wr_status ? i_bus.wdata[rsr_pkg::IRQ_WIDTH-1:0] : '0)) | irq_events;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_status_q & irq_mask_q);
        end
    end

    // Read port, data one cycle after strobe; unmapped reads zero
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 16'h0000;
        end else if (i_bus.rd) begin
            case (i_bus.addr)
                rsr_pkg::ADDR_HUB_LINK_STATE: o_rdata <= link_word_q; // [RL11]
                rsr_pkg::ADDR_CONTROL:        o_rdata <= control_q;
                rsr_pkg::ADDR_MONITOR_LO:     o_rdata <= monitor_q[15:0];
                rsr_pkg::ADDR_MONITOR_HI:     o_rdata <= {10'h000, monitor_q[N-1:16]};
                rsr_pkg::ADDR_DISC_TIME:      o_rdata <= disc_time_q;
                rsr_pkg::ADDR_IRQ_STATUS:     o_rdata <= {13'h0000, irq_status_q};
                rsr_pkg::ADDR_IRQ_MASK:       o_rdata <= {13'h0000, irq_mask_q};
                rsr_pkg::ADDR_ERR_LO:         o_rdata <= err_latch_q[15:0];
                rsr_pkg::ADDR_ERR_HI:         o_rdata <= {10'h000, err_latch_q[N-1:16]};
                default:                      o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/rsr_host_model.sv
// Host CPU model that receives switch requests
`timescale 1ns/10ps
`default_nettype none
module rsr_host_model (
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_req,
    input  wire logic       i_standby_err,
    input  wire logic       i_peer_ok,
    output logic [7:0]      o_req_count,
    output logic [7:0]      o_switch_count
);
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_req_count    <= 8'h00;
            o_switch_count <= 8'h00;
        end else if (i_req) begin
            o_req_count <= o_req_count + 8'h01;
            // Never switch onto a failed standby or past a healthy peer
            if (!i_standby_err && !i_peer_ok) begin
                o_switch_count <= o_switch_count + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/rsr_switch_request_chk.sv
// Port checker for the switch request block
`timescale 1ns/10ps
`default_nettype none
module rsr_switch_request_chk (
    input wire logic                           i_clk,
    input wire logic                           i_reset_n,
    input wire rsr_pkg::rsr_bus_req_type       i_bus,
    input wire logic [15:0]                    o_rdata,
    input wire rsr_pkg::rsr_conn_event_type    i_conn,
    input wire logic                           i_link_up,
    input wire logic                           o_switch_req,
    input wire logic [rsr_pkg::CONN_COUNT-1:0] o_conn_close,
    input wire logic                           o_send_error,
    input wire logic                           o_irq
);
    logic en_q;
    logic act_q;
    logic fault;
    assign fault = (o_conn_close != '0) || o_send_error;
    // Shadow of the enable and active control bits, taken from bus writes
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            en_q  <= 1'b0;
            act_q <= 1'b0;
        end else if (i_bus.wr && i_bus.addr == rsr_pkg::ADDR_CONTROL) begin
            en_q  <= i_bus.wdata[rsr_pkg::CTRL_REQ_ENABLE_BIT];
            act_q <= i_bus.wdata[rsr_pkg::CTRL_ACTIVE_BIT];
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    AST_CLOSE_TO_REQ: assert property ((o_conn_close != '0) && en_q && act_q |=> o_switch_req)
        else $error("close without request");
    AST_SEND_TO_REQ: assert property (o_send_error && en_q && act_q |=> o_switch_req)
        else $error("send error without request");
    AST_CLOSE_CAUSE: assert property ((o_conn_close != '0) |->
        (o_conn_close & ~$past(i_conn.open & i_conn.alive_fail)) == '0)
        else $error("close without presence failure");
    AST_SEND_CAUSE: assert property (o_send_error |-> $past(|(i_conn.open & i_conn.ack_fail)))
        else $error("send error without ack failure");
    AST_NO_REPEAT: assert property (o_conn_close[2] && i_conn.open[2] ##1
        i_conn.open[2] [*2] |-> !o_conn_close[2])
        else $error("close repeated while open");
    AST_ACTIVE_ONLY: assert property (o_switch_req |-> act_q || $past(act_q))
        else $error("request while not active");
    AST_ENABLE_GATES: assert property (fault && !en_q |=> !o_switch_req)
        else $error("request while issuing disabled");
    AST_LINK_PERSIST: assert property (o_switch_req && !$past(fault) |->
        !($past(i_link_up, 2) && $past(i_link_up, 3) && $past(i_link_up, 4)))
        else $error("link request without loss");
    AST_LINK_WORD: assert property (i_bus.rd && i_bus.addr == rsr_pkg::ADDR_HUB_LINK_STATE
        |=> o_rdata[15:1] == '0)
        else $error("link word out of range");
    COV_IRQ: cover property (o_irq);
endmodule
bind rsr_switch_request rsr_switch_request_chk u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_bus(i_bus), .o_rdata(o_rdata), .i_conn(i_conn), .i_link_up(i_link_up),
    .o_switch_req(o_switch_req), .o_conn_close(o_conn_close),
    .o_send_error(o_send_error), .o_irq(o_irq));
`default_nettype wire

// >>> testbench/rsr_switch_request_tb.sv
// Self-checking bench for the switch request block
`timescale 1ns/10ps
`default_nettype none
module rsr_switch_request_tb;
    typedef struct {
        int         idx;
        logic       ack;
        logic       mon;
        logic [1:0] ctl;
        logic [2:0] exp;
    } rsr_row_type;
    logic                        i_clk;
    logic                        i_reset_n;
    rsr_pkg::rsr_bus_req_type    bus;
    rsr_pkg::rsr_conn_event_type conn;
    logic                        link;
    logic [15:0]                 rdata;
    logic                        req;
    logic [21:0]                 close;
    logic                        send_err;
    logic                        irq;
    logic                        sb_err;
    logic                        peer_ok;
    logic [7:0]                  n_req;
    logic [7:0]                  n_sw;
    logic [21:0]                 mon;
    int                          miscompares;
    int                          checks_done;
    // Fields: connection, ack kind, monitored, {active, enable}, {close, send, request}
    rsr_row_type rows [7] = '{'{0, 1'b0, 1'b1, 2'b11, 3'b101}, '{15, 1'b1, 1'b1, 2'b11, 3'b011},
        '{16, 1'b0, 1'b1, 2'b11, 3'b101}, '{21, 1'b1, 1'b1, 2'b11, 3'b011},
        '{3, 1'b0, 1'b0, 2'b11, 3'b000}, '{5, 1'b0, 1'b1, 2'b10, 3'b100},
        '{7, 1'b1, 1'b1, 2'b01, 3'b010}};
    rsr_switch_request dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_bus(bus), .o_rdata(rdata),
        .i_conn(conn), .i_link_up(link), .o_switch_req(req), .o_conn_close(close),
        .o_send_error(send_err), .o_irq(irq));
    rsr_host_model host (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(req),
        .i_standby_err(sb_err), .i_peer_ok(peer_ok), .o_req_count(n_req), .o_switch_count(n_sw));
    task automatic check(input string what, input logic [21:0] seen, input logic [21:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge i_clk);
        bus <= '0;
    endtask
    task automatic bus_rd(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge i_clk);
        bus <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge i_clk);
        bus <= '0;
        #1;
        check(what, {6'h00, rdata}, {6'h00, exp});
    endtask
    // Fault level lasts one cycle; the connection stays open afterwards
    task automatic fire(input int k, input logic ack);
        @(posedge i_clk);
        conn.open[k] <= 1'b1;
        if (ack) conn.ack_fail[k] <= 1'b1;
        else conn.alive_fail[k] <= 1'b1;
        @(posedge i_clk);
        conn.alive_fail <= '0;
        conn.ack_fail <= '0;
        #1;
    endtask
    task automatic finish_test;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_clk);
        miscompares++;
        finish_test;
    end
    initial begin
        {bus, conn, link, sb_err, peer_ok, i_reset_n} = '0;
        miscompares = 0;
        checks_done = 0;
        repeat (10) @(posedge i_clk);
        #1;
        check("close in reset", close, 22'h000000);
        check("flags in reset", {19'h00000, req, send_err, irq}, 22'h000000);
        @(posedge i_clk);
        i_reset_n <= 1'b1;
        bus_rd(rsr_pkg::ADDR_HUB_LINK_STATE, rsr_pkg::LINK_LOST_WORD, "link word");
        bus_rd(rsr_pkg::ADDR_CONTROL, rsr_pkg::CONTROL_RESET, "control");
        bus_rd(rsr_pkg::ADDR_DISC_TIME, rsr_pkg::DISC_TIME_RESET, "disc time");
        bus_wr(rsr_pkg::ADDR_HUB_LINK_STATE, 16'hFFFF);
        bus_rd(rsr_pkg::ADDR_HUB_LINK_STATE, rsr_pkg::LINK_LOST_WORD, "ro word");
        bus_rd(8'h10, 16'h0000, "unmapped");
        $display("test reset done");
        foreach (rows[r]) begin
            mon = '0;
            mon[rows[r].idx] = rows[r].mon;
            bus_wr(rsr_pkg::ADDR_MONITOR_LO, mon[15:0]);
            bus_wr(rsr_pkg::ADDR_MONITOR_HI, {10'h000, mon[21:16]});
            bus_wr(rsr_pkg::ADDR_CONTROL, {14'h0000, rows[r].ctl});
            fire(rows[r].idx, rows[r].ack);
            check("close", close, 22'(rows[r].exp[2]) << rows[r].idx);
            check("send error", {21'h000000, send_err}, {21'h000000, rows[r].exp[1]});
            @(posedge i_clk);
            #1;
            check("request", {21'h000000, req}, {21'h000000, rows[r].exp[0]});
            @(posedge i_clk);
            conn.open <= '0;
        end
        $display("test connection rows done");
        bus_wr(rsr_pkg::ADDR_MONITOR_LO, 16'hFFFF);
        sb_err <= 1'b1;
        bus_wr(rsr_pkg::ADDR_CONTROL, 16'h0003);
        fire(2, 1'b0);
        check("first close", close, 22'h000004);
        fire(2, 1'b0);
        check("repeat close", close, 22'h000000);
        bus_rd(rsr_pkg::ADDR_ERR_LO, 16'h0004, "error latch");
        @(posedge i_clk);
        conn.open <= '0;
        sb_err <= 1'b0;
        peer_ok <= 1'b1;
        fire(4, 1'b1);
        check("send error", {21'h000000, send_err}, 22'h000001);
        repeat (2) @(posedge i_clk);
        conn.open <= '0;
        peer_ok <= 1'b0;
        link <= 1'b1;
        $display("test latch and host done");
        bus_wr(rsr_pkg::ADDR_IRQ_MASK, 16'h0007);
        link <= 1'b0;
        bus_wr(rsr_pkg::ADDR_CONTROL, 16'h0006);
        repeat (20) @(posedge i_clk);
        bus_rd(rsr_pkg::ADDR_HUB_LINK_STATE, rsr_pkg::LINK_LOST_WORD, "never up");
        check("requests", {14'h0000, n_req}, 22'h000006);
        bus_wr(rsr_pkg::ADDR_IRQ_STATUS, 16'h0007);
        link <= 1'b1;
        repeat (10) @(posedge i_clk);
        bus_rd(rsr_pkg::ADDR_HUB_LINK_STATE, rsr_pkg::LINK_GOOD_WORD, "link good");
        @(posedge i_clk);
        link <= 1'b0;
        repeat (10) @(posedge i_clk);
        bus_rd(rsr_pkg::ADDR_HUB_LINK_STATE, rsr_pkg::LINK_LOST_WORD, "link lost");
        @(posedge i_clk);
        link <= 1'b1;
        repeat (10) @(posedge i_clk);
        check("requests", {14'h0000, n_req}, 22'h000006);
        bus_rd(rsr_pkg::ADDR_IRQ_STATUS, 16'h0004, "status");
        bus_wr(rsr_pkg::ADDR_IRQ_STATUS, 16'h0007);
        bus_wr(rsr_pkg::ADDR_DISC_TIME, 16'h0000);
        link <= 1'b0;
        repeat (20) @(posedge i_clk);
        check("requests", {14'h0000, n_req}, 22'h000007);
        bus_rd(rsr_pkg::ADDR_IRQ_STATUS, 16'h0006, "status");
        check("irq", {21'h000000, irq}, 22'h000001);
        bus_wr(rsr_pkg::ADDR_IRQ_STATUS, 16'h0007);
        repeat (2) @(posedge i_clk);
        #1;
        check("irq", {21'h000000, irq}, 22'h000000);
        check("switchovers", {14'h0000, n_sw}, 22'h000005);
        $display("test link done");
        // Mid-run reset with the link up: registers return, detector stays unarmed
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        link <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (10) @(posedge i_clk);
        bus_rd(rsr_pkg::ADDR_CONTROL, rsr_pkg::CONTROL_RESET, "control after reset");
        bus_rd(rsr_pkg::ADDR_DISC_TIME, rsr_pkg::DISC_TIME_RESET, "disc after reset");
        bus_rd(rsr_pkg::ADDR_HUB_LINK_STATE, rsr_pkg::LINK_LOST_WORD, "not armed");
        $display("test mid-run reset done");
        finish_test;
    end
endmodule
`default_nettype wire
